// *** core/ccsel_core.sv ***
// Purpose: feed selection, failover, key gating, fault lamps and alarms
// Assumes: keys and detector flags synchronous to pclk, keys active high
// Notes: all state in one struct; registers reached over APB
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ccsel_core #(
    parameter int BLINK_CYC = ccsel_pkg::BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire ccsel_pkg::ccsel_apb_req_t apb_req,
    output ccsel_pkg::ccsel_apb_rsp_t apb_rsp,
    // panel
    input wire ccsel_pkg::ccsel_cfg_t panel_cfg,
    input wire ccsel_pkg::ccsel_keys_t keys,
    // detectors
    input wire logic [ccsel_pkg::NFLT-1:0] fault_main,
    input wire logic [ccsel_pkg::NFLT-1:0] fault_spare,
    input wire logic [ccsel_pkg::NAMP-1:0] amp_err,
    input wire logic psu_err,
    input wire logic [1:0] psu_off,
    // selection and lamps
    output ccsel_pkg::ccsel_feed_t feed_sel,
    output logic net_ctrl,
    output logic [ccsel_pkg::NFLT-1:0] chan_lamp_main,
    output logic [ccsel_pkg::NFLT-1:0] chan_lamp_spare,
    output logic [1:0] summary_error_lamp,
    output logic [ccsel_pkg::NAMP-1:0] amp_bypass,
    output logic [ccsel_pkg::NAMP-1:0] out_alarm_lamp,
    output logic power_alarm,
    output logic [1:0] psu_lamp
);
    import ccsel_pkg::*;

    ccsel_state_t s_q;
    ccsel_state_t s_d;
    ccsel_cfg_t eff;
    logic fm;
    logic fs;
    logic cur_bad;
    logic oth_bad;
    logic press_sel;
    logic press_ctrl;
    logic press_rst;
    logic auto_sw;
    logic key_ok;
    logic setup;
    logic access;
    ccsel_feed_t other;

    assign eff = s_q.net_ctrl ? s_q.net : panel_cfg;
    assign fm = |fault_main;
    assign fs = |fault_spare;
    assign cur_bad = (s_q.sel == FEED_SPARE) ? fs : fm;
    assign oth_bad = (s_q.sel == FEED_SPARE) ? fm : fs;
    assign other = (s_q.sel == FEED_MAIN) ? FEED_SPARE : FEED_MAIN;
    assign press_sel = keys.sel & ~s_q.key_prev.sel;
    assign press_ctrl = keys.ctrl & ~s_q.key_prev.ctrl;
    assign press_rst = keys.rst & ~s_q.key_prev.rst;
    // one policy for every channel, never per channel
    assign auto_sw = (eff.policy == POL_FAILOVER) && cur_bad && !oth_bad;
    // refuse only a move onto a faulted feed while the current one is healthy
    assign key_ok = (fm == fs)
        || (eff.policy == POL_DISABLED && eff.mode == MODE_UNRESTRICTED)
        || !oth_bad;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;

    always_comb begin
        s_d = s_q;
        s_d.key_prev = keys;
        // automatic move wins over a key press in the same cycle
        if (auto_sw) begin
            s_d.sel = other;
        end else if (press_sel && key_ok) begin
            s_d.sel = other;
        end
        if (press_ctrl) begin
            s_d.net_ctrl = ~s_q.net_ctrl;
        end
        // new faults win over the reset key in the same cycle
        s_d.flt_m = (press_rst ? '0 : s_q.flt_m) | fault_main;
        s_d.flt_s = (press_rst ? '0 : s_q.flt_s) | fault_spare;
        s_d.alm = (press_rst ? '0 : s_q.alm) | amp_err;
        if (s_q.blink_cnt >= BLINK_CYC - 1) begin
            s_d.blink_cnt = '0;
            s_d.blink = ~s_q.blink;
        end else begin
            s_d.blink_cnt = s_q.blink_cnt + 32'h1;
        end
        s_d.pwr_alarm = psu_err | (|psu_off);
        s_d.psu_lamp = psu_off;
        // read data and error sampled in setup so the access phase is one cycle
        if (setup) begin
            s_d.prdata = '0;
            s_d.slverr = 1'b0;
            if (apb_req.paddr == OFF_CTRL) begin
                s_d.prdata[CTRL_POL_BIT] = s_q.net.policy;
                s_d.prdata[CTRL_MODE_BIT] = s_q.net.mode;
                s_d.prdata[CTRL_AEN_BIT] = s_q.net.alarm_en;
            end else if (apb_req.paddr == OFF_STAT) begin
                s_d.prdata[STAT_SEL_BIT] = s_q.sel;
                s_d.prdata[STAT_NET_BIT] = s_q.net_ctrl;
                s_d.prdata[STAT_POL_BIT] = eff.policy;
                s_d.prdata[STAT_MODE_BIT] = eff.mode;
                s_d.prdata[STAT_AEN_BIT] = eff.alarm_en;
                s_d.prdata[STAT_FM_BIT] = fm;
                s_d.prdata[STAT_FS_BIT] = fs;
                s_d.prdata[STAT_PWR_BIT] = s_q.pwr_alarm;
            end else if (apb_req.paddr == OFF_FLTM) begin
                s_d.prdata[NFLT-1:0] = s_q.flt_m;
            end else if (apb_req.paddr == OFF_FLTS) begin
                s_d.prdata[NFLT-1:0] = s_q.flt_s;
            end else if (apb_req.paddr == OFF_ALM) begin
                s_d.prdata[NAMP-1:0] = s_q.alm;
            end else begin
                s_d.slverr = 1'b1;
            end
        end
        // network values persist while the panel is in charge
        if (access && apb_req.pwrite && apb_req.paddr == OFF_CTRL) begin
            s_d.net.policy = ccsel_pol_t'(apb_req.pwdata[CTRL_POL_BIT]);
            s_d.net.mode = ccsel_mode_t'(apb_req.pwdata[CTRL_MODE_BIT]);
            s_d.net.alarm_en = apb_req.pwdata[CTRL_AEN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.sel <= RST_SEL;
            s_q.net_ctrl <= RST_NET_CTRL;
            s_q.net.policy <= RST_NET_POL;
            s_q.net.mode <= RST_NET_MODE;
            s_q.net.alarm_en <= RST_NET_AEN;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access & s_q.slverr;
    assign apb_rsp.prdata = s_q.prdata;

    assign feed_sel = s_q.sel;
    assign net_ctrl = s_q.net_ctrl;
    assign chan_lamp_main = s_q.flt_m;
    assign chan_lamp_spare = s_q.flt_s;
    assign summary_error_lamp[0] = (|s_q.flt_m) & s_q.blink;
    assign summary_error_lamp[1] = (|s_q.flt_s) & s_q.blink;
    assign power_alarm = s_q.pwr_alarm;
    assign psu_lamp = s_q.psu_lamp;

    // bypass follows the latched error even with lamps switched off
    for (genvar i = 0; i < NAMP; i++) begin : g_amp
        assign amp_bypass[i] = s_q.alm[i];
        assign out_alarm_lamp[i] = s_q.alm[i] & eff.alarm_en;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sel_press_s;
        press_sel && !auto_sw;
    endsequence
    sequence rst_press_s;
        press_rst;
    endsequence

    auto_fail_a: assert property (auto_sw |=> feed_sel != $past(feed_sel))
        else $error("failover did not change feed");
    no_auto_dis_a: assert property ((eff.policy == POL_DISABLED && !press_sel) |=> $stable(feed_sel))
        else $error("feed changed without key under disabled policy");
    both_keep_a: assert property ((fm && fs && !press_sel) |=> $stable(feed_sel))
        else $error("feed changed with both feeds faulted");
    key_toggle_a: assert property ((fm == fs) and sel_press_s |=> feed_sel != $past(feed_sel))
        else $error("key press did not toggle feed");
    key_block_a: assert property (
        (sel_press_s and (!cur_bad && oth_bad
        && !(eff.policy == POL_DISABLED && eff.mode == MODE_UNRESTRICTED)))
        |=> $stable(feed_sel))
        else $error("key selected a faulted feed");
    free_toggle_a: assert property ((sel_press_s and (eff.policy == POL_DISABLED
        && eff.mode == MODE_UNRESTRICTED)) |=> feed_sel != $past(feed_sel))
        else $error("unrestricted key press ignored");
    ctrl_toggle_a: assert property (press_ctrl |=> net_ctrl != $past(net_ctrl))
        else $error("control key did not toggle source");
    lamp_latch_a: assert property ((fault_main[0] ##1 (!fault_main[0] && !press_rst)[*2])
        |-> chan_lamp_main[0])
        else $error("fault lamp did not stay latched");
    alarm_keep_a: assert property ((rst_press_s and amp_err[0]) |=> amp_bypass[0])
        else $error("alarm cleared while error persists");
    alarm_dark_a: assert property (!eff.alarm_en |-> out_alarm_lamp == '0)
        else $error("output alarm lamp lit while disabled");
    power_off_a: assert property (psu_off[1] |=> power_alarm && psu_lamp[1])
        else $error("power alarm missing for unpowered supply");

endmodule // ccsel_core

// *** core/ccsel_pkg.sv ***
// Purpose: shared constants and types of the changeover selector control
// Assumes: 200 MHz pclk, APB register access
// Notes: channels 1-11 plus three time-code lines form one fault vector per feed
package ccsel_pkg;
    localparam int NFLT = 14;
    localparam int NAMP = 9;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FLTM = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FLTS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_ALM = 8'h10;

    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_AEN_BIT = 2;

    localparam int STAT_SEL_BIT = 0;
    localparam int STAT_NET_BIT = 1;
    localparam int STAT_POL_BIT = 2;
    localparam int STAT_MODE_BIT = 3;
    localparam int STAT_AEN_BIT = 4;
    localparam int STAT_FM_BIT = 5;
    localparam int STAT_FS_BIT = 6;
    localparam int STAT_PWR_BIT = 7;

    typedef enum logic {FEED_MAIN, FEED_SPARE} ccsel_feed_t;
    typedef enum logic {POL_DISABLED, POL_FAILOVER} ccsel_pol_t;
    typedef enum logic {MODE_GUARDED, MODE_UNRESTRICTED} ccsel_mode_t;

    localparam ccsel_feed_t RST_SEL = FEED_MAIN;
    localparam ccsel_pol_t RST_NET_POL = POL_FAILOVER;
    localparam ccsel_mode_t RST_NET_MODE = MODE_GUARDED;
    localparam logic RST_NET_AEN = 1'b1;
    localparam logic RST_NET_CTRL = 1'b0;

    localparam int BLINK_HALF_MS = 250;
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

    typedef struct packed {
        ccsel_pol_t policy;
        ccsel_mode_t mode;
        logic alarm_en;
    } ccsel_cfg_t;

    typedef struct packed {
        logic sel;
        logic ctrl;
        logic rst;
    } ccsel_keys_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ccsel_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ccsel_apb_rsp_t;

    typedef struct packed {
        ccsel_feed_t sel;
        logic net_ctrl;
        ccsel_cfg_t net;
        ccsel_keys_t key_prev;
        logic [NFLT-1:0] flt_m;
        logic [NFLT-1:0] flt_s;
        logic [NAMP-1:0] alm;
        logic [31:0] blink_cnt;
        logic blink;
        logic pwr_alarm;
        logic [1:0] psu_lamp;
        logic [31:0] prdata;
        logic slverr;
    } ccsel_state_t;
endpackage

// *** verification/ccsel_panel_model.sv ***
// Purpose: panel keys and fault detector stand-in
// Assumes: driven just after pclk rising edges
// Notes: keys drop low between presses so each press is a fresh edge
`timescale 1ns/1ps
module ccsel_panel_model (
    // clock
    input wire logic pclk,
    // keys and detector flags
    output ccsel_pkg::ccsel_keys_t keys,
    output logic [ccsel_pkg::NFLT-1:0] fault_main,
    output logic [ccsel_pkg::NFLT-1:0] fault_spare
);
    import ccsel_pkg::*;
    initial begin
        keys = '0;
        fault_main = '0;
        fault_spare = '0;
    end
    // k: 0 select, 1 control, 2 reset
    task automatic press(input int k);
        @(posedge pclk);
        keys <= ccsel_keys_t'(3'b100 >> k);
        @(posedge pclk);
        keys <= '0;
        @(posedge pclk);
    endtask
    task automatic set_flt(input logic [NFLT-1:0] m, input logic [NFLT-1:0] s);
        @(posedge pclk);
        fault_main <= m;
        fault_spare <= s;
        repeat (2) @(posedge pclk);
    endtask
endmodule // ccsel_panel_model

// *** verification/testbench.sv ***
// Purpose: self-checking bench of the changeover selector control
// Assumes: zero-wait APB, blink half period cut to 4 cycles
// Notes: keys and fault flags come from the panel model
`timescale 1ns/1ps
module testbench;
    import ccsel_pkg::*;
    logic pclk, presetn, net_ctrl, power_alarm, psu_err, err, on, off;
    ccsel_apb_req_t apb_req;
    ccsel_apb_rsp_t apb_rsp;
    ccsel_cfg_t panel_cfg;
    ccsel_keys_t keys;
    ccsel_feed_t feed_sel;
    logic [NFLT-1:0] fault_main, fault_spare, chan_lamp_main, chan_lamp_spare;
    logic [NAMP-1:0] amp_err, amp_bypass, out_alarm_lamp;
    logic [1:0] summary_error_lamp, psu_off, psu_lamp;
    logic [31:0] rd;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    ccsel_panel_model pm (.pclk(pclk), .keys(keys), .fault_main(fault_main),
        .fault_spare(fault_spare));
    ccsel_core #(.BLINK_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .panel_cfg(panel_cfg), .keys(keys), .fault_main(fault_main),
        .fault_spare(fault_spare), .amp_err(amp_err), .psu_err(psu_err), .psu_off(psu_off),
        .feed_sel(feed_sel), .net_ctrl(net_ctrl), .chan_lamp_main(chan_lamp_main),
        .chan_lamp_spare(chan_lamp_spare), .summary_error_lamp(summary_error_lamp),
        .amp_bypass(amp_bypass), .out_alarm_lamp(out_alarm_lamp),
        .power_alarm(power_alarm), .psu_lamp(psu_lamp));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) @(posedge pclk);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic sel_chk(input int k, input string name, input ccsel_feed_t exp);
        pm.press(k);
        #1;
        chk(name, feed_sel, exp);
    endtask
    // blink seen as both levels, or dark throughout when exp is low, over three half periods
    task automatic blink_chk(input int b, input logic exp);
        on = 1'b0;
        off = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            #1;
            on |= summary_error_lamp[b];
            off |= !summary_error_lamp[b];
        end
        chk("blink", {on, off}, {exp, 1'b1});
    endtask
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        panel_cfg = '{policy: POL_FAILOVER, mode: MODE_GUARDED, alarm_en: 1'b1};
        amp_err = '0;
        psu_err = 1'b0;
        psu_off = 2'b00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("feed", feed_sel, FEED_MAIN);
        chk("net_ctrl", net_ctrl, 1'b0);
        apb(1'b0, OFF_CTRL, '0);
        chk("ctrl", rd, 32'h5);
        sel_chk(0, "toggle", FEED_SPARE);
        sel_chk(0, "toggle", FEED_MAIN);
        pm.set_flt(14'h2000, '0);
        #1;
        chk("failover", feed_sel, FEED_SPARE);
        chk("lamp", chan_lamp_main, 14'h2000);
        blink_chk(0, 1'b1);
        pm.set_flt(14'h0001, '0);
        #1;
        chk("latch", chan_lamp_main, 14'h2001);
        sel_chk(0, "refuse", FEED_SPARE);
        pm.set_flt(14'h0001, 14'h0002);
        #1;
        chk("both", feed_sel, FEED_SPARE);
        sel_chk(0, "both key", FEED_MAIN);
        pm.set_flt('0, '0);
        pm.press(2);
        #1;
        chk("clear", {chan_lamp_main, chan_lamp_spare}, 28'h0);
        blink_chk(1, 1'b0);
        @(posedge pclk);
        panel_cfg.policy <= POL_DISABLED;
        pm.set_flt(14'h0004, '0);
        #1;
        chk("no auto", feed_sel, FEED_MAIN);
        sel_chk(0, "leave", FEED_SPARE);
        sel_chk(0, "guarded", FEED_SPARE);
        @(posedge pclk);
        panel_cfg.mode <= MODE_UNRESTRICTED;
        sel_chk(0, "free", FEED_MAIN);
        @(posedge pclk);
        amp_err <= 9'h001;
        settle();
        chk("alarm", {amp_bypass, out_alarm_lamp}, 18'h00201);
        pm.press(2);
        #1;
        chk("kept", out_alarm_lamp, 9'h001);
        @(posedge pclk);
        panel_cfg.alarm_en <= 1'b0;
        amp_err <= 9'h000;
        settle();
        chk("dark", {amp_bypass, out_alarm_lamp}, 18'h00200);
        pm.press(2);
        #1;
        chk("gone", amp_bypass, 9'h000);
        // walk every amplifier channel so no bypass bit goes untested
        for (int i = 0; i < NAMP; i++) begin
            @(posedge pclk);
            amp_err <= 9'h001 << i;
            settle();
            chk("bypass", amp_bypass, 9'h001 << i);
            @(posedge pclk);
            amp_err <= '0;
            pm.press(2);
            #1;
        end
        // each supply off in turn lights its own lamp
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            psu_off <= 2'b01 << i;
            settle();
            chk("psu off", {power_alarm, psu_lamp}, {1'b1, 2'b01 << i});
        end
        @(posedge pclk);
        psu_off <= 2'b00;
        psu_err <= 1'b1;
        settle();
        chk("psu err", power_alarm, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h1);
        pm.press(1);
        #1;
        chk("net", net_ctrl, 1'b1);
        apb(1'b0, OFF_STAT, '0);
        chk("net cfg", rd[4:2], 3'b001);
        pm.press(1);
        apb(1'b0, OFF_STAT, '0);
        chk("panel cfg", rd[4:2], 3'b010);
        pm.press(1);
        apb(1'b0, OFF_STAT, '0);
        chk("restore", rd[4:2], 3'b001);
        apb(1'b0, 8'h20, '0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        end_of_test();
    end
endmodule // testbench
